// ---- ssq_pkg.sv ----
// Constants, state codes and carriers for the supply state sequencer.
// Assumes a single 40 MHz clock and a 32-bit classic Wishbone register bus.
package ssq_pkg;

  // ==========================================================
  // Operating states, one-hot
  typedef enum logic [3:0] {
    SSQ_ACTIVE   = 4'b0001,
    SSQ_FAULT    = 4'b0010,
    SSQ_LOCKED   = 4'b0100,
    SSQ_DISABLED = 4'b1000
  } ssq_state_t;

  // ==========================================================
  // Timing
  localparam int unsigned SSQ_CLK_HZ = 40000000;
  localparam int unsigned SSQ_FAULT_TIME_MS = 20;
  localparam int unsigned SSQ_FAULT_CYC = (SSQ_FAULT_TIME_MS * (SSQ_CLK_HZ / 1000));
  localparam int unsigned SSQ_SEVERE_LOCK = 3;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] SSQ_OFS_CTRL = 4'h0;
  localparam logic [3:0] SSQ_OFS_CFG = 4'h4;
  localparam logic [3:0] SSQ_OFS_STATUS = 4'h8;
  localparam logic [3:0] SSQ_OFS_EVENT = 4'hC;

  // Control fields
  localparam int SSQ_CTRL_REQ_DIS = 0;
  localparam int SSQ_CTRL_REQ_LOCK = 1;
  localparam int SSQ_CTRL_STYLE = 2;

  // Rail and block enables, all on after reset
  localparam int SSQ_CFG_W = 5;
  localparam logic [SSQ_CFG_W-1:0] SSQ_CFG_RST = 5'h1F;

  // Event bits
  localparam int SSQ_EV_W = 6;
  localparam int SSQ_EV_HARD = 0;
  localparam int SSQ_EV_INIT = 1;
  localparam int SSQ_EV_ESC = 2;
  localparam int SSQ_EV_REQ = 3;
  localparam int SSQ_EV_IRQ = 4;
  localparam int SSQ_EV_LOCK = 5;
  // Subset that survives entry into LOCKED
  localparam logic [SSQ_EV_W-1:0] SSQ_EV_LOCK_KEEP = 6'h22;

  // ==========================================================
  // Supervisor events, same clock domain, one-cycle pulses
  typedef struct packed {
    logic rail_hard;     // Rail fault that forces FAULT
    logic rail_soft;     // Rail fault that asks for an mcu reset
    logic rail_irq;      // Rail warning, log only
    logic sup_overflow;  // Watchdog error counter overflow
    logic spi_valid;     // Valid serial frame from host
    logic wd_serviced;   // Watchdog serviced correctly
  } ssq_event_t;

  // Rail and block enables towards the regulators
  typedef struct packed {
    logic main_step_down_rail;
    logic second_step_down_rail;
    logic step_up_rail;
    logic external_monitor_one;
    logic external_monitor_two;
    logic window_watchdog;
  } ssq_rails_t;

endpackage

// ---- ssq_sequencer.sv ----
// Supply state sequencer: ACTIVE/FAULT/LOCKED/DISABLED control, mcu reset
// output, start-up timer and programming mode, with a Wishbone register file.
// Assumes supervisor events arrive as same-clock pulses; pins are asynchronous.
//
// Notes on behaviour
// - Programming mode follows the synchronised mode select pin level.
// - In programming mode watchdog overflow never pulls the mcu reset.
// - Rail resets, event logging and transitions work unchanged in programming mode.
// - Start-up timer held cleared while programming mode is active.
// - State machine ignores programming mode; any transition stays possible.
// - Rail supervision still logs warnings and forces FAULT in programming mode.
// - After reset enter ACTIVE with all rails on, await configuration.
// - Start-up timer starts when the mcu reset output is released.
// - Timer stops once valid serial traffic and watchdog service both seen.
// - First timer expiry gives soft reset: mcu reset, no state change.
// - Second expiry gives hard reset: rails off, enter FAULT.
// - Host DISABLED or LOCKED request dwells 20 ms in FAULT first.
// - DISABLED waits for wake pin enable event, then ACTIVE.
// - Entering DISABLED clears every register to reset value.
// - FAULT turns rails off, holds mcu reset, then returns to ACTIVE unless DISABLED or LOCKED is due.
// - FAULT keeps event register and severe fault count, resets all other registers.
// - Repeated rail soft fault escalates to FAULT; watchdog overflow exempt.
// - Three start-up severe faults or host request lead to LOCKED, low power.
// - LOCKED keeps only the lock and start-up expiry event bits, clears the rest.
// - Configuration writable only in ACTIVE; main rail never configurable.
// - Mcu reset output low outside ACTIVE; edges only in ACTIVE.
// - FAULT to LOCKED only with wake pin low; the style bit is always cleared in FAULT.
`timescale 1ns/1ps
module ssq_sequencer
  import ssq_pkg::*;
#(
  parameter int unsigned FAULT_CYC = SSQ_FAULT_CYC,
  parameter int unsigned INIT_CYC = 8000,
  parameter int unsigned RST_CYC = 64
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins
  input wire logic programming_mode_select_i,
  input wire logic wake_pin_i,
  // Supervisor events
  input wire ssq_event_t event_i,
  // Outputs to the system
  output logic mcu_reset_out_o,
  output ssq_rails_t rails_o,
  output logic low_power_o
);

  localparam int FW = $clog2(FAULT_CYC + 1);
  localparam int IW = $clog2(INIT_CYC + 1);
  localparam int RW = $clog2(RST_CYC + 1);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] pm_sync_q;
  logic [1:0] wake_sync_q;
  logic wake_prev_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pm_sync_q <= 2'b00;
      wake_sync_q <= 2'b00;
      wake_prev_q <= 1'b0;
    end
    else
    begin
      pm_sync_q <= {pm_sync_q[0], programming_mode_select_i};
      wake_sync_q <= {wake_sync_q[0], wake_pin_i};
      wake_prev_q <= wake_sync_q[1];
    end
  end
  logic pm;
  logic wake;
  assign pm = pm_sync_q[1];
  assign wake = wake_sync_q[1];

  // ==========================================================
  // Declarations
  ssq_state_t state_q;
  ssq_state_t state_d;
  ssq_state_t target_q;
  logic style_q;
  logic [SSQ_CFG_W-1:0] cfg_q;
  logic [SSQ_EV_W-1:0] evt_q;
  logic [FW-1:0] dwell_q;
  logic [IW-1:0] init_cnt_q;
  logic [RW-1:0] rst_cnt_q;
  logic rot_q;
  logic init_run_q;
  logic spi_ok_q;
  logic wd_ok_q;
  logic init_err_q;
  logic soft_seen_q;
  logic [1:0] severe_q;
  logic bus_req;
  logic bus_wr;
  logic host_dis;
  logic host_lock;
  logic init_exp;
  logic soft_go;
  logic hard_go;
  logic dwell_done;
  logic enable_ev;
  logic lock_ok;

  assign bus_req = cyc_i & stb_i & ~ack_o;
  // Writes land on the edge where the master samples ack, with the request still held
  assign bus_wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  assign host_dis = bus_wr & (adr_i == SSQ_OFS_CTRL) & dat_i[SSQ_CTRL_REQ_DIS];
  assign host_lock = bus_wr & (adr_i == SSQ_OFS_CTRL) & dat_i[SSQ_CTRL_REQ_LOCK]
    & ~host_dis;

  // ==========================================================
  // Event decode
  // Timer expiry only counts while running; cleared counter under prog mode
  assign init_exp = init_run_q & ~pm & (init_cnt_q == IW'(INIT_CYC - 1));
  // Watchdog overflow masked in programming mode; rail soft faults are not
  assign soft_go = (event_i.sup_overflow & ~pm)
    | (event_i.rail_soft & ~soft_seen_q)
    | (init_exp & ~init_err_q);
  assign hard_go = event_i.rail_hard
    | (event_i.rail_soft & soft_seen_q)
    | (init_exp & init_err_q);
  assign dwell_done = (dwell_q == FW'(FAULT_CYC - 1));
  // style_q is always clear off ACTIVE, so LOCKED and DISABLED wake on a high wake level
  assign enable_ev = style_q ? (wake & ~wake_prev_q) : wake;
  assign lock_ok = style_q | ~wake;

  // ==========================================================
  // Next state; programming mode deliberately not an input here
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SSQ_ACTIVE:
      begin
        if (hard_go)
          state_d = SSQ_FAULT;
        else if (host_dis || host_lock)
          state_d = SSQ_FAULT;
      end
      SSQ_FAULT:
      begin
        if (dwell_done)
        begin
          if (target_q == SSQ_DISABLED)
            state_d = SSQ_DISABLED;
          else if ((target_q == SSQ_LOCKED || severe_q == 2'(SSQ_SEVERE_LOCK)) && lock_ok)
            state_d = SSQ_LOCKED;
          else
            state_d = SSQ_ACTIVE;
        end
      end
      SSQ_LOCKED, SSQ_DISABLED:
      begin
        if (enable_ev)
          state_d = SSQ_ACTIVE;
      end
      default:
        state_d = SSQ_ACTIVE;
    endcase
  end

  // ==========================================================
  // State, dwell counter and requested target
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= SSQ_ACTIVE;
      target_q <= SSQ_ACTIVE;
      dwell_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == SSQ_ACTIVE && host_dis && !hard_go)
        target_q <= SSQ_DISABLED;
      else if (state_q == SSQ_ACTIVE && host_lock && !hard_go)
        target_q <= SSQ_LOCKED;
      else if (state_d != SSQ_FAULT)
        target_q <= SSQ_ACTIVE;
      // Dwell counts only inside FAULT, restarts on each entry
      if (state_q == SSQ_FAULT && !dwell_done)
        dwell_q <= dwell_q + FW'(1);
      else
        dwell_q <= '0;
    end
  end

  // ==========================================================
  // Severe start-up fault count; survives FAULT, ends on LOCKED or DISABLED
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      severe_q <= 2'b00;
    else if (state_d == SSQ_LOCKED || state_d == SSQ_DISABLED)
      severe_q <= 2'b00;
    else if (state_q == SSQ_ACTIVE && init_exp && init_err_q)
      severe_q <= severe_q + 2'b01;
  end

  // ==========================================================
  // Mcu reset pulse; low whenever the next state is not ACTIVE
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rot_q <= 1'b0;
      rst_cnt_q <= '0;
    end
    else if (state_d != SSQ_ACTIVE)
    begin
      rot_q <= 1'b0;
      rst_cnt_q <= '0;
    end
    else if (state_q != SSQ_ACTIVE || (soft_go && rot_q))
    begin
      rot_q <= 1'b0;
      rst_cnt_q <= '0;
    end
    else if (!rot_q)
    begin
      // Release after the reset delay
      if (rst_cnt_q == RW'(RST_CYC - 1))
        rot_q <= 1'b1;
      else
        rst_cnt_q <= rst_cnt_q + RW'(1);
    end
  end

  // ==========================================================
  // Start-up configuration timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != SSQ_ACTIVE || !rot_q)
    begin
      init_cnt_q <= '0;
      spi_ok_q <= 1'b0;
      wd_ok_q <= 1'b0;
      init_run_q <= 1'b0;
    end
    else
    begin
      if (!init_run_q && !spi_ok_q)
        init_run_q <= 1'b1;
      if (event_i.spi_valid)
        spi_ok_q <= 1'b1;
      if (event_i.wd_serviced)
        wd_ok_q <= 1'b1;
      if ((spi_ok_q || event_i.spi_valid) && (wd_ok_q || event_i.wd_serviced))
        init_run_q <= 1'b0;
      if (pm || init_exp)
        init_cnt_q <= '0;
      else if (init_run_q)
        init_cnt_q <= init_cnt_q + IW'(1);
      // A soft reset restarts the whole sequence on release
      if (soft_go)
      begin
        spi_ok_q <= 1'b0;
        wd_ok_q <= 1'b0;
        init_run_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Soft-fault history for escalation; watchdog overflow not tracked
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_d != SSQ_ACTIVE)
    begin
      init_err_q <= 1'b0;
      soft_seen_q <= 1'b0;
    end
    else
    begin
      if (init_exp)
        init_err_q <= 1'b1;
      if (event_i.rail_soft)
        soft_seen_q <= 1'b1;
    end
  end

  // ==========================================================
  // Configuration registers: writable in ACTIVE only, cleared off ACTIVE
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_d != SSQ_ACTIVE)
    begin
      cfg_q <= SSQ_CFG_RST;
      style_q <= 1'b0;
    end
    else if (bus_wr && state_q == SSQ_ACTIVE)
    begin
      if (adr_i == SSQ_OFS_CFG)
        cfg_q <= dat_i[SSQ_CFG_W-1:0];
      if (adr_i == SSQ_OFS_CTRL)
        style_q <= dat_i[SSQ_CTRL_STYLE];
    end
  end

  // ==========================================================
  // Event register, write one to clear; a new event beats the clear
  logic [SSQ_EV_W-1:0] ev_set;
  logic [SSQ_EV_W-1:0] ev_clr;
  always_comb
  begin
    ev_set = '0;
    ev_set[SSQ_EV_HARD] = (state_q == SSQ_ACTIVE) & hard_go;
    ev_set[SSQ_EV_INIT] = init_exp;
    ev_set[SSQ_EV_ESC] = event_i.rail_soft & soft_seen_q;
    ev_set[SSQ_EV_REQ] = host_dis | host_lock;
    ev_set[SSQ_EV_IRQ] = event_i.rail_irq;
    // Only a lock forced by repeated severe faults is a fault cause
    ev_set[SSQ_EV_LOCK] = (state_q == SSQ_FAULT) & (state_d == SSQ_LOCKED)
      & (severe_q == 2'(SSQ_SEVERE_LOCK));
    ev_clr = (bus_wr && adr_i == SSQ_OFS_EVENT) ? dat_i[SSQ_EV_W-1:0] : '0;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_q <= '0;
    else if (state_d == SSQ_DISABLED && state_q != SSQ_DISABLED)
      evt_q <= '0;
    else if (state_d == SSQ_LOCKED && state_q != SSQ_LOCKED)
      evt_q <= (evt_q | ev_set) & SSQ_EV_LOCK_KEEP;
    else
      evt_q <= (evt_q & ~ev_clr) | ev_set;
  end

  // ==========================================================
  // Wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= '0;
      if (bus_req && !we_i)
      begin
        case (adr_i)
          SSQ_OFS_CTRL: dat_o[SSQ_CTRL_STYLE] <= style_q;
          SSQ_OFS_CFG: dat_o[SSQ_CFG_W-1:0] <= cfg_q;
          SSQ_OFS_STATUS: dat_o[9:0] <= {severe_q, init_err_q, init_run_q, pm, 1'b0, state_q};
          SSQ_OFS_EVENT: dat_o[SSQ_EV_W-1:0] <= evt_q;
          default: dat_o <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs; rails follow the next state so they drop with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rails_o <= '0;
      low_power_o <= 1'b0;
    end
    else
    begin
      rails_o.main_step_down_rail <= (state_d == SSQ_ACTIVE);
      rails_o.second_step_down_rail <= (state_d == SSQ_ACTIVE) & cfg_q[4];
      rails_o.step_up_rail <= (state_d == SSQ_ACTIVE) & cfg_q[3];
      rails_o.external_monitor_one <= (state_d == SSQ_ACTIVE) & cfg_q[2];
      rails_o.external_monitor_two <= (state_d == SSQ_ACTIVE) & cfg_q[1];
      rails_o.window_watchdog <= (state_d == SSQ_ACTIVE) & cfg_q[0];
      low_power_o <= (state_d == SSQ_LOCKED);
    end
  end
  assign mcu_reset_out_o = rot_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_first_expiry;
    init_exp && !init_err_q && state_q == SSQ_ACTIVE && !hard_go;
  endsequence
  sequence s_host_req;
    state_q == SSQ_ACTIVE && (host_dis || host_lock) && !hard_go;
  endsequence

  property p_pm_masks_sup;
    pm && rot_q && state_q == SSQ_ACTIVE && event_i.sup_overflow && !event_i.rail_soft
      && !event_i.rail_hard && !init_exp && !host_dis && !host_lock |=> rot_q;
  endproperty
  a_pm_masks_sup: assert property (p_pm_masks_sup) else $error("prog mode reset leak");

  property p_pm_timer;
    pm |=> init_cnt_q == '0;
  endproperty
  a_pm_timer: assert property (p_pm_timer) else $error("timer ran in prog mode");

  property p_timer_start;
    state_q == SSQ_ACTIVE && $rose(rot_q) && state_d == SSQ_ACTIVE |=> init_run_q;
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer not started");

  property p_soft_reset;
    s_first_expiry |=> !mcu_reset_out_o && state_q == SSQ_ACTIVE;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

  property p_hard_reset;
    init_exp && init_err_q && state_q == SSQ_ACTIVE |=> state_q == SSQ_FAULT && !rails_o.main_step_down_rail;
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("hard reset wrong");

  property p_host_req;
    s_host_req |=> state_q == SSQ_FAULT [*8];
  endproperty
  a_host_req: assert property (p_host_req) else $error("no fault dwell");

  property p_rot_low;
    state_q != SSQ_ACTIVE |-> !mcu_reset_out_o && rails_o == '0;
  endproperty
  a_rot_low: assert property (p_rot_low) else $error("reset or rails on off ACTIVE");

  property p_wake;
    state_q == SSQ_DISABLED && enable_ev |=> state_q == SSQ_ACTIVE ##1 !mcu_reset_out_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not honoured");

  property p_dis_clear;
    $rose(state_q == SSQ_DISABLED) |-> evt_q == '0 && cfg_q == SSQ_CFG_RST && !style_q;
  endproperty
  a_dis_clear: assert property (p_dis_clear) else $error("registers kept");

  property p_lock_gate;
    state_q == SSQ_FAULT && !style_q && wake |=> state_q != SSQ_LOCKED;
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("locked with level wake high");

endmodule

// ---- ssq_host_model.sv ----
// Host microcontroller model: serial frames, watchdog service, mode pin.
// Assumes the bench asks for one service by a one-cycle pulse on svc_i.
`timescale 1ns/1ps
module ssq_host_model
  import ssq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic svc_i,
  input wire logic [3:0] lag_i,
  input wire logic prog_i,
  // Towards the device
  output logic spi_valid_o,
  output logic wd_serviced_o,
  output logic programming_mode_select_o
);
  logic [4:0] cnt_q;
  // Frame first, service lag cycles later; a long lag plays a slow host
  always_ff @(posedge clk_i)
  begin
    spi_valid_o <= 1'b0;
    wd_serviced_o <= 1'b0;
    if (rst_i)
      cnt_q <= 5'h00;
    else if (svc_i)
      cnt_q <= {1'b0, lag_i} + 5'h02;
    else if (cnt_q != 5'h00)
    begin
      cnt_q <= cnt_q - 5'h01;
      spi_valid_o <= (cnt_q == {1'b0, lag_i} + 5'h01);
      wd_serviced_o <= (cnt_q == 5'h01);
    end
  end
  // Mode pin follows the bench prog input, held low during reset
  always_ff @(posedge clk_i)
    programming_mode_select_o <= prog_i & ~rst_i;
endmodule

// ---- ssq_sequencer_test.sv ----
// Self-checking bench for the supply state sequencer, seeded random stimulus.
// Assumes the host model supplies frames, watchdog service and the mode pin.
`timescale 1ns/1ps
module ssq_sequencer_test;
  import ssq_pkg::*;
  // ==========
  // Shortened counts keep the run brief
  localparam int unsigned FC = 200;
  localparam int unsigned IC = 300;
  localparam int unsigned RC = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic wake = 1'b0;
  logic prog = 1'b0;
  logic svc = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [3:0] tev = 4'h0;
  logic spi_v;
  logic wd_s;
  logic programming_mode_select;
  logic mrst;
  logic lowp;
  ssq_event_t ev;
  ssq_rails_t rails_o;
  logic [31:0] seed = 32'h6B6CC1C0;
  int mismatches = 0;
  int total_checks = 0;

  // Bench rail and watchdog overflow events beside host service pulses
  assign ev = {tev, spi_v, wd_s};
  always #12.5 clk_i = ~clk_i;
  ssq_sequencer #(.FAULT_CYC(FC), .INIT_CYC(IC), .RST_CYC(RC)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .programming_mode_select_i(programming_mode_select), .wake_pin_i(wake),
    .event_i(ev), .mcu_reset_out_o(mrst), .rails_o(rails_o), .low_power_o(lowp));
  ssq_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .svc_i(svc), .lag_i(lag), .prog_i(prog),
    .spi_valid_o(spi_v), .wd_serviced_o(wd_s), .programming_mode_select_o(programming_mode_select));

  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Level watched by span: reset output or any rail on
  function automatic logic hi(input logic w);
    return w ? (rails_o !== 6'h00) : mrst;
  endfunction
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    check(n == 2, "ack latency");
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hF, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string msg);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hF, r);
    check((r & m) === e, msg);
  endtask
  task automatic wait_st(input logic [3:0] e, input int lim);
    logic [31:0] r;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, SSQ_OFS_STATUS, 32'h0, 4'hF, r);
      n++;
    end
    while (r[3:0] !== e && n < lim);
    check(r[3:0] === e, "state not reached");
  endtask
  // Cycles until the level falls, then cycles it stays low
  task automatic span(input logic w, input int lim, output int n, output int len);
    n = 0;
    len = 0;
    while (hi(w) !== 1'b0 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    while (hi(w) === 1'b0 && len < 4000)
    begin
      @(posedge clk_i);
      len++;
    end
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk_i);
    tev <= v;
    @(posedge clk_i);
    tev <= 4'h0;
  endtask
  task automatic serve();
    @(posedge clk_i);
    seed = xs(seed);
    lag <= seed[3:0];
    svc <= 1'b1;
    @(posedge clk_i);
    svc <= 1'b0;
    // Longest lag plus pipeline; later status reads expect the timer stopped
    tick(20);
  endtask
  // Back in ACTIVE, wait for reset release, then service the timer if s is set
  task automatic recover(input logic s);
    int n;
    int len;
    wait_st(4'h1, 100);
    span(1'b0, 1, n, len);
    if (s)
      serve();
  endtask
  task automatic wake_up();
    tick(1);
    wake <= 1'b1;
    wait_st(4'h1, 20);
    wake <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========
  // Watchdog well beyond the expected run
  initial
  begin
    #1000000;
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end

  // ==========
  // Main sequence
  initial
  begin
    int n;
    int len;
    logic [31:0] r;
    logic [4:0] c;
    tick(5);
    rst_i <= 1'b0;
    tick(2);
    check(rails_o === 6'h3F, "rails at power-on");
    rd(SSQ_OFS_STATUS, 32'h0F, 32'h01, "power-on state");
    span(1'b0, 1, n, len);
    check(len <= RC && mrst === 1'b1, "reset not released");
    serve();
    span(1'b0, IC + 40, n, len);
    check(len == 0, "timer not stopped");
    rd(SSQ_OFS_STATUS, 32'h40, 32'h00, "timer running");
    $display("test power_on done");
    repeat (4)
    begin
      seed = xs(seed);
      c = seed[4:0];
      wr(SSQ_OFS_CFG, {27'h0, c});
      rd(SSQ_OFS_CFG, 32'h1F, {27'h0, c}, "cfg readback");
      check(rails_o === {1'b1, c}, "rail enables");
    end
    wb(1'b1, SSQ_OFS_CFG, 32'h0, 4'hE, r);
    rd(SSQ_OFS_CFG, 32'h1F, {27'h0, c}, "write without byte 0");
    rd({seed[3:2], 2'b01}, 32'hFFFFFFFF, 32'h0, "unmapped read");
    $display("test config done");
    wr(SSQ_OFS_CFG, 32'h05);
    pulse(4'h4);
    span(1'b0, 10, n, len);
    check(len == RC, "soft reset length");
    repeat (2)
    begin
      pulse(4'h1);
      span(1'b0, 10, n, len);
      check(len == RC, "overflow reset");
    end
    rd(SSQ_OFS_STATUS, 32'h0F, 32'h01, "overflow escalated");
    pulse(4'h4);
    tick(4);
    check(rails_o === 6'h00 && mrst === 1'b0, "fault outputs");
    rd(SSQ_OFS_EVENT, 32'h04, 32'h04, "escalation event");
    rd(SSQ_OFS_CFG, 32'h1F, 32'h1F, "cfg after fault");
    wr(SSQ_OFS_CFG, 32'h00);
    rd(SSQ_OFS_CFG, 32'h1F, 32'h1F, "cfg write in fault");
    recover(1'b1);
    $display("test escalation done");
    tick(1);
    prog <= 1'b1;
    tick(4);
    rd(SSQ_OFS_STATUS, 32'h60, 32'h20, "mode on, timer held");
    pulse(4'h1);
    span(1'b0, 20, n, len);
    check(len == 0, "overflow reset in mode");
    pulse(4'h4);
    span(1'b0, 10, n, len);
    check(len == RC, "rail reset in mode");
    pulse(4'h2);
    rd(SSQ_OFS_EVENT, 32'h10, 32'h10, "rail warning");
    pulse(4'h8);
    span(1'b1, 6, n, len);
    check(len >= FC - 1 && len <= FC + 1, "fault dwell");
    recover(1'b0);
    span(1'b0, IC + 40, n, len);
    check(len == 0, "timer in mode");
    prog <= 1'b0;
    serve();
    $display("test programming done");
    wr(SSQ_OFS_CFG, 32'h0A);
    wr(SSQ_OFS_CTRL, 32'h01);
    rd(SSQ_OFS_STATUS, 32'h0F, 32'h02, "request via fault");
    tick(FC - 20);
    rd(SSQ_OFS_STATUS, 32'h0F, 32'h02, "dwell too short");
    tick(30);
    rd(SSQ_OFS_STATUS, 32'h0F, 32'h08, "disabled");
    rd(SSQ_OFS_EVENT, 32'h3F, 32'h00, "events kept");
    wr(SSQ_OFS_CFG, 32'h00);
    rd(SSQ_OFS_CFG, 32'h1F, 32'h1F, "cfg not cleared");
    check(rails_o === 6'h00 && mrst === 1'b0, "disabled outputs");
    wake_up();
    recover(1'b1);
    $display("test disable done");
    // Level-style wake held high blocks the lock and the dwell ends in ACTIVE
    wake <= 1'b1;
    wr(SSQ_OFS_CTRL, 32'h02);
    tick(FC + 10);
    rd(SSQ_OFS_STATUS, 32'h0F, 32'h01, "locked with wake high");
    wake <= 1'b0;
    wr(SSQ_OFS_CTRL, 32'h02);
    wait_st(4'h4, 100);
    check(lowp === 1'b1 && rails_o === 6'h00 && mrst === 1'b0, "locked outputs");
    rd(SSQ_OFS_EVENT, 32'h3F, 32'h00, "locked events");
    wake_up();
    recover(1'b0);
    $display("test lock done");
    span(1'b0, IC + 20, n, len);
    check(n >= IC - 2 && n <= IC + 2 && len == RC, "first expiry");
    rd(SSQ_OFS_STATUS, 32'h8F, 32'h81, "state after expiry");
    check(rails_o === 6'h3F, "rails after soft reset");
    span(1'b0, IC + 20, n, len);
    check(n >= IC - 2 && n <= IC + 2 && len >= FC, "second expiry");
    rd(SSQ_OFS_STATUS, 32'h30F, 32'h101, "severe count");
    wait_st(4'h4, 700);
    rd(SSQ_OFS_EVENT, 32'h3F, 32'h22, "locked cause");
    check(lowp === 1'b1, "low power");
    wake_up();
    $display("test start_up done");
    complete_run();
  end
endmodule
